/* dfc_host.sv */
// Purpose: Host model driving the register port
// Assumes: Read data valid one cycle after the read strobe
// Notes:   Strobes last one cycle, changed just after an edge
`timescale 1ns/1ps
module dfc_host (
	// Clock
	input  wire logic        clk,
	// Register port
	output logic [3:0]       addr,
	output logic [7:0]       wdata,
	output logic             wr,
	output logic             rd,
	input  wire logic [12:0] rdata
);
	initial begin
		{addr, wdata, wr, rd} = '0;
	end
	// One write cycle
	task automatic put(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge clk) wr <= 1'b0;
	endtask
	// One read cycle; data taken after the strobe edge settles
	task automatic get(input logic [3:0] a, output logic [12:0] r);
		@(posedge clk) {addr, rd} <= {a, 1'b1};
		@(posedge clk) rd <= 1'b0;
		@(posedge clk) r = rdata;
	endtask
endmodule // dfc_host

/* dfc_pkg.sv */
// Purpose: Shared constants for the diagnostic fault and command register bank
// Assumes: 25 MHz system clock, registers reached by a word-wide register port
// Notes:   Offsets are register indices on that port

package dfc_pkg;
	// Register port geometry
	localparam int ADDR_W  = 4;
	localparam int WDATA_W = 8;
	localparam int RDATA_W = 13;
	localparam int ANG_W   = 12;
	localparam int CNT_W   = 20;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_DIAG_FAULT_STATUS = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_COMMAND_CONTROL   = 4'h8;

	// diag_fault_status field positions
	localparam int DIAG_LINE_CODE_FAULT   = 6;
	localparam int DIAG_LOGIC_ST_FAIL     = 4;
	localparam int DIAG_XDCR_ST_FAIL      = 3;

	// command_control field positions
	localparam int CMD_SELFTEST_TRIGGER   = 4;
	localparam int CMD_TURN_CLEAR         = 3;
	localparam int CMD_SPEED_MODE         = 2;
	localparam int CMD_LOW_POWER_SELECT   = 1;
	localparam int CMD_FAULT_CLEAR        = 0;

	// Reset values
	localparam logic [RDATA_W-1:0] DIAG_RESET   = 13'h0000;
	localparam logic               LPSEL_RESET  = 1'b0;
	localparam logic               SPEED_RESET  = 1'b0;

	// Self-test choice bits from nonvolatile memory
	localparam int CHOICE_LOGIC = 0;
	localparam int CHOICE_XDCR  = 1;

	// Timing
	localparam int CLK_HZ            = 25_000_000;
	localparam int LOGIC_TEST_MS     = 10;
	localparam int XDCR_TEST_MS      = 40;
	localparam int LOGIC_TEST_CYCLES = LOGIC_TEST_MS * (CLK_HZ / 1000);
	localparam int XDCR_TEST_CYCLES  = XDCR_TEST_MS * (CLK_HZ / 1000);

	// Self-test sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOGIC,
		ST_XDCR
	} dfc_test_e;
endpackage

/* dfc_regs.sv */
// Purpose: Secondary fault status, command register, self-test windows, zeroed angle
// Assumes: All inputs come from logic on SYS_CLK; the serial front end decodes frames
// Notes:   Read data appear one cycle after the read strobe

`timescale 1ns/1ps

// Contract
// - Secondary fault bits stay set until fault clear, hard reset or power-on reset.
// - Serial error indication asserts whenever any unmasked fault bit is set.
// - Masked fault bits still set but do not drive the error indication.
// - Bit 6 reads one after a line-code link error; read only.
// - Bit 4 reads one after a failed logic self-test.
// - Bit 3 reads one after a failed transducer self-test.
// - Bits 0,1,2,5 factory reserved, bits 12 to 7 unused; host ignores them.
// - Write-one command fields execute at once, clear, and read as zero.
// - Command bit 4 written one starts the chosen self-tests; zero does nothing.
// - Logic self-test lasts about 10 ms with no angle measurement.
// - Transducer self-test lasts about 40 ms with no angle readings.
// - Command bit 3 written one clears the turn count register.
// - Speed-mode bit loads its stored default at power-up; writes override temporarily.
// - Internal averaging allowed only while command bit 2 is one.
// - Command bit 1 picks low-power or transport mode for next request.
// - Command bit 0 written one clears the primary fault register.
// - Output angle equals raw angle minus reference angle.
module dfc_regs #(
	parameter logic [dfc_pkg::CNT_W-1:0] LOGIC_CYCLES = dfc_pkg::CNT_W'(dfc_pkg::LOGIC_TEST_CYCLES),
	parameter logic [dfc_pkg::CNT_W-1:0] XDCR_CYCLES  = dfc_pkg::CNT_W'(dfc_pkg::XDCR_TEST_CYCLES)
) (
	// Clock and resets
	input  wire logic                          SYS_CLK,
	input  wire logic                          NRST,
	input  wire logic                          HARD_RST,
	// Register port
	input  wire logic [dfc_pkg::ADDR_W-1:0]    REG_ADDR,
	input  wire logic [dfc_pkg::WDATA_W-1:0]   REG_WDATA,
	input  wire logic                          REG_WR,
	input  wire logic                          REG_RD,
	output logic      [dfc_pkg::RDATA_W-1:0]   REG_RDATA,
	// Fault sources and masks
	input  wire logic                          LINE_CODE_ERR,
	input  wire logic                          LOGIC_TEST_PASS,
	input  wire logic                          XDCR_TEST_PASS,
	input  wire logic [dfc_pkg::RDATA_W-1:0]   FAULT_MASK,
	output logic                               SPI_ERROR_FLAG,
	// Nonvolatile defaults
	input  wire logic [1:0]                    SELFTEST_CHOICE,
	input  wire logic                          SPEED_MODE_DEFAULT,
	// Command effects
	output logic                               TURN_CLEAR,
	output logic                               PRIMARY_FAULT_CLEAR,
	output logic                               AVG_ENABLE,
	output logic                               LOW_POWER_TRANSPORT,
	output logic                               LOGIC_TEST_BUSY,
	output logic                               XDCR_TEST_BUSY,
	// Angle path
	input  wire logic [dfc_pkg::ANG_W-1:0]     RAW_ANGLE,
	input  wire logic                          RAW_VALID,
	input  wire logic [dfc_pkg::ANG_W-1:0]     REF_ANGLE,
	output logic      [dfc_pkg::ANG_W-1:0]     ANGLE_OUT
);
	// Register port decode
	logic                            cmd_wr;
	logic                            cmd_rd;
	logic                            diag_rd;
	logic                            fault_clr;
	logic                            turn_clr;
	logic                            trig_wr;
	// Fault state
	logic [dfc_pkg::RDATA_W-1:0]     diag_r;
	logic [dfc_pkg::RDATA_W-1:0]     fault_set;
	logic                            err_any;
	logic                            logic_fail;
	logic                            xdcr_fail;
	// Command state
	logic                            speed_r;
	logic                            lpsel_r;
	logic                            loaded_r;
	logic [dfc_pkg::RDATA_W-1:0]     cmd_view;
	// Self-test sequencer and its timer
	dfc_pkg::dfc_test_e              state_r;
	dfc_pkg::dfc_test_e              state_nxt;
	logic                            launch;
	logic [dfc_pkg::CNT_W-1:0]       launch_len;
	logic                            tmr_running;
	logic                            tmr_done;
	logic                            test_idle;
	// Zeroed angle
	logic [dfc_pkg::ANG_W-1:0]       angle_diff;

	// True when a port strobe targets the given register
	function automatic logic hits(input logic [dfc_pkg::ADDR_W-1:0] addr,
		input logic strobe, input logic [dfc_pkg::ADDR_W-1:0] ofs);
		return strobe && (addr == ofs);
	endfunction

	// Readable view of the fault word; spare and unused bits always read zero
	function automatic logic [dfc_pkg::RDATA_W-1:0] visible(
		input logic [dfc_pkg::RDATA_W-1:0] raw);
		logic [dfc_pkg::RDATA_W-1:0] keep;
		keep = '0;
		keep[dfc_pkg::DIAG_LINE_CODE_FAULT] = 1'b1;
		keep[dfc_pkg::DIAG_LOGIC_ST_FAIL]   = 1'b1;
		keep[dfc_pkg::DIAG_XDCR_ST_FAIL]    = 1'b1;
		return raw & keep;
	endfunction

	// Strobe decode; write-one fields act only in the write cycle itself
	always_comb begin
		cmd_wr    = hits(REG_ADDR, REG_WR, dfc_pkg::OFS_COMMAND_CONTROL);
		cmd_rd    = hits(REG_ADDR, REG_RD, dfc_pkg::OFS_COMMAND_CONTROL);
		diag_rd   = hits(REG_ADDR, REG_RD, dfc_pkg::OFS_DIAG_FAULT_STATUS);
		fault_clr = cmd_wr && REG_WDATA[dfc_pkg::CMD_FAULT_CLEAR];
		turn_clr  = cmd_wr && REG_WDATA[dfc_pkg::CMD_TURN_CLEAR];
		trig_wr   = cmd_wr && REG_WDATA[dfc_pkg::CMD_SELFTEST_TRIGGER];
	end

	// Fault events; a failing test reports only when its window closes
	always_comb begin
		test_idle  = (state_r == dfc_pkg::ST_IDLE);
		logic_fail = (state_r == dfc_pkg::ST_LOGIC) && tmr_done && !LOGIC_TEST_PASS;
		xdcr_fail  = (state_r == dfc_pkg::ST_XDCR) && tmr_done && !XDCR_TEST_PASS;
		fault_set  = '0;
		fault_set[dfc_pkg::DIAG_LINE_CODE_FAULT] = LINE_CODE_ERR;
		fault_set[dfc_pkg::DIAG_LOGIC_ST_FAIL]   = logic_fail;
		fault_set[dfc_pkg::DIAG_XDCR_ST_FAIL]    = xdcr_fail;
	end

	// Sticky fault bits; a new event wins over a clear in the same cycle
	// so that a fault arriving during the clear is never lost
	genvar gi;
	generate
		for (gi = 0; gi < dfc_pkg::RDATA_W; gi++) begin : g_sticky
			always_ff @(posedge SYS_CLK or negedge NRST) begin
				if (!NRST) begin
					diag_r[gi] <= dfc_pkg::DIAG_RESET[gi];
				end else if (fault_set[gi]) begin
					diag_r[gi] <= 1'b1;
				end else if (fault_clr || HARD_RST) begin
					diag_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Error indication; masked bits stay in the register but stay silent
	assign err_any = |(visible(diag_r) & ~FAULT_MASK);

	// Registered error flag for the serial responses
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			SPI_ERROR_FLAG <= 1'b0;
		end else begin
			SPI_ERROR_FLAG <= err_any;
		end
	end

	// Speed and low-power bits; the stored default loads in the first cycle
	// after power-on reset, so a write landing in that cycle is lost
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			loaded_r <= 1'b0;
			speed_r  <= dfc_pkg::SPEED_RESET;
			lpsel_r  <= dfc_pkg::LPSEL_RESET;
		end else if (!loaded_r) begin
			loaded_r <= 1'b1;
			speed_r  <= SPEED_MODE_DEFAULT;
		end else if (cmd_wr) begin
			speed_r <= REG_WDATA[dfc_pkg::CMD_SPEED_MODE];
			lpsel_r <= REG_WDATA[dfc_pkg::CMD_LOW_POWER_SELECT];
		end
	end

	// Mode outputs come straight from the command flops
	assign AVG_ENABLE          = speed_r;
	assign LOW_POWER_TRANSPORT = lpsel_r;

	// Command word view; write-one fields always read zero
	always_comb begin
		cmd_view = '0;
		cmd_view[dfc_pkg::CMD_SPEED_MODE]       = speed_r;
		cmd_view[dfc_pkg::CMD_LOW_POWER_SELECT] = lpsel_r;
	end

	// One-cycle command pulses towards the turn counter and primary faults
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			TURN_CLEAR          <= 1'b0;
			PRIMARY_FAULT_CLEAR <= 1'b0;
		end else begin
			TURN_CLEAR          <= turn_clr;
			PRIMARY_FAULT_CLEAR <= fault_clr;
		end
	end

	// Self-test sequencer; logic test first, then the transducer test
	always_comb begin
		state_nxt  = state_r;
		launch     = 1'b0;
		launch_len = LOGIC_CYCLES;
		unique case (state_r)
			dfc_pkg::ST_IDLE: begin
				if (trig_wr && SELFTEST_CHOICE[dfc_pkg::CHOICE_LOGIC]) begin
					state_nxt = dfc_pkg::ST_LOGIC;
					launch    = 1'b1;
				end else if (trig_wr && SELFTEST_CHOICE[dfc_pkg::CHOICE_XDCR]) begin
					state_nxt  = dfc_pkg::ST_XDCR;
					launch     = 1'b1;
					launch_len = XDCR_CYCLES;
				end
			end
			dfc_pkg::ST_LOGIC: begin
				if (tmr_done && SELFTEST_CHOICE[dfc_pkg::CHOICE_XDCR]) begin
					state_nxt  = dfc_pkg::ST_XDCR;
					launch     = 1'b1;
					launch_len = XDCR_CYCLES;
				end else if (tmr_done) begin
					state_nxt = dfc_pkg::ST_IDLE;
				end
			end
			dfc_pkg::ST_XDCR: begin
				if (tmr_done) begin
					state_nxt = dfc_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = dfc_pkg::ST_IDLE;
			end
		endcase
	end

	// Sequencer state and busy flags; further triggers are ignored while busy
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			state_r         <= dfc_pkg::ST_IDLE;
			LOGIC_TEST_BUSY <= 1'b0;
			XDCR_TEST_BUSY  <= 1'b0;
		end else begin
			state_r         <= state_nxt;
			LOGIC_TEST_BUSY <= (state_nxt == dfc_pkg::ST_LOGIC);
			XDCR_TEST_BUSY  <= (state_nxt == dfc_pkg::ST_XDCR);
		end
	end

	// One timer is shared, since the two windows never overlap
	dfc_test_timer i_dfc_test_timer (
		.clk     (SYS_CLK),
		.nrst    (NRST),
		.start   (launch),
		.length  (launch_len),
		.running (tmr_running),
		.done    (tmr_done)
	);

	// Zeroed angle; frozen while a self-test owns the front end
	assign angle_diff = RAW_ANGLE - REF_ANGLE;
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			ANGLE_OUT <= '0;
		end else if (RAW_VALID && test_idle) begin
			ANGLE_OUT <= angle_diff;
		end
	end

	// Read data register; holds its value until the next read
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			REG_RDATA <= '0;
		end else if (diag_rd) begin
			REG_RDATA <= visible(diag_r);
		end else if (cmd_rd) begin
			REG_RDATA <= cmd_view;
		end
	end

	// Steps of a logic self-test window
	sequence s_logic_launch;
		test_idle && trig_wr && SELFTEST_CHOICE[dfc_pkg::CHOICE_LOGIC];
	endsequence
	sequence s_logic_busy;
		LOGIC_TEST_BUSY [*8];
	endsequence

	a_logic_window: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		s_logic_launch |=> s_logic_busy)
		else $error("logic self-test window ended early");
	a_timer_tracks: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(!test_idle && !tmr_done) |-> tmr_running)
		else $error("self-test busy without a running timer");
	a_fault_sticky: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(diag_r[dfc_pkg::DIAG_LINE_CODE_FAULT] && !fault_clr && !HARD_RST)
		|=> diag_r[dfc_pkg::DIAG_LINE_CODE_FAULT])
		else $error("line-code fault bit dropped without a clear");
	a_err_raise: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		err_any |=> SPI_ERROR_FLAG)
		else $error("error flag missing for an unmasked fault");
	a_err_masked: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		!err_any |=> !SPI_ERROR_FLAG)
		else $error("error flag raised with all faults masked or clear");
	a_logic_fail_bit: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		logic_fail |=> diag_r[dfc_pkg::DIAG_LOGIC_ST_FAIL])
		else $error("logic self-test failure not recorded");
	a_xdcr_fail_bit: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		xdcr_fail |=> diag_r[dfc_pkg::DIAG_XDCR_ST_FAIL])
		else $error("transducer self-test failure not recorded");
	a_trigger_zero: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(test_idle && cmd_wr && !REG_WDATA[dfc_pkg::CMD_SELFTEST_TRIGGER]) |=> test_idle)
		else $error("self-test started without a trigger");
	a_turn_pulse: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		turn_clr |=> TURN_CLEAR)
		else $error("turn count clear pulse missing");
	a_fault_pulse: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		!fault_clr |=> !PRIMARY_FAULT_CLEAR)
		else $error("primary fault clear without a command");
	a_angle_hold: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(LOGIC_TEST_BUSY || XDCR_TEST_BUSY) |=> $stable(ANGLE_OUT))
		else $error("angle changed during a self-test");
	a_angle_math: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(RAW_VALID && test_idle) |=> (ANGLE_OUT == $past(angle_diff)))
		else $error("output angle is not raw minus reference");
endmodule // dfc_regs

/* dfc_regs_bench.sv */
// Purpose: Self-checking bench for dfc_regs
// Assumes: Self-test windows shortened to 20 and 40 cycles
// Notes:   Expected values come from the bench model
`timescale 1ns/1ps
module dfc_regs_bench;
	logic clk = 0, nrst = 0, hr = 0, lce = 0, lp = 1, xp = 1, spd = 1, ef, av, lpt, lb, xb;
	logic wr, rd, tc, pfc;
	logic [1:0]  sel = 0;
	logic [12:0] msk = 0, q, r;
	logic [11:0] raw = 0, rf = 0, ao;
	logic [7:0]  d, c;
	logic [3:0]  a;
	int bad_count = 0, num_checks = 0, nl = 0, nx = 0, ntc = 0, npf = 0;
	int m_diag = 0;
	int m_q[$];
	// 25 MHz clock
	always #20 clk = ~clk;
	// Count command pulses seen at the design outputs
	always @(posedge clk) begin
		ntc <= ntc + int'(tc);
		npf <= npf + int'(pfc);
	end
	dfc_host i_dfc_host (.clk(clk), .addr(a), .wdata(d), .wr(wr), .rd(rd), .rdata(q));
	dfc_regs #(.LOGIC_CYCLES(20'h14), .XDCR_CYCLES(20'h28)) i_dfc_regs (.SYS_CLK(clk),
		.NRST(nrst), .HARD_RST(hr), .REG_ADDR(a), .REG_WDATA(d), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(q), .LINE_CODE_ERR(lce), .LOGIC_TEST_PASS(lp),
		.XDCR_TEST_PASS(xp), .FAULT_MASK(msk), .SPI_ERROR_FLAG(ef),
		.SELFTEST_CHOICE(sel), .SPEED_MODE_DEFAULT(spd), .TURN_CLEAR(tc),
		.PRIMARY_FAULT_CLEAR(pfc), .AVG_ENABLE(av), .LOW_POWER_TRANSPORT(lpt),
		.LOGIC_TEST_BUSY(lb), .XDCR_TEST_BUSY(xb), .RAW_ANGLE(raw), .RAW_VALID(1'b1),
		.REF_ANGLE(rf), .ANGLE_OUT(ao));
	// Compare one result
	task automatic chk(input logic [12:0] g, input logic [12:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Compare a register read against the model queue
	task automatic chk_reg(input logic [12:0] g);
		int e;
		e = m_q.pop_front();
		chk(g, 13'(e));
	endtask
	// Read a register and queue the model's expectation
	task automatic rd_chk(input logic [3:0] ad, input int e);
		m_q.push_back(e);
		i_dfc_host.get(ad, r);
		chk_reg(r);
	endtask
	// One-cycle line-code error event
	task automatic pulse_lce;
		@(posedge clk) lce <= 1;
		@(posedge clk) lce <= 0;
	endtask
	// Bounded wait over the self-test windows; busy left up is a mismatch
	task automatic wait_tests;
		nl = 0;
		nx = 0;
		repeat (150) begin
			@(posedge clk);
			nl += int'(lb);
			nx += int'(xb);
		end
		chk({lb, xb}, 0);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'ha91e));
		repeat (8) @(posedge clk);
		nrst <= 1;
		rd_chk(4'h8, 13'h4);
		c = 8'($urandom) | 8'h09;
		i_dfc_host.put(4'h8, c);
		rd_chk(4'h8, int'(c & 8'h06));
		chk({av, lpt}, c[2:1]);
		chk(ntc, 1);
		chk(npf, 1);
		pulse_lce;
		m_diag = 'h40;
		rd_chk(4'h5, m_diag);
		chk(ef, 1);
		@(posedge clk) msk <= 13'h40;
		rd_chk(4'h5, m_diag);
		chk(ef, 0);
		i_dfc_host.put(4'h8, 8'h01);
		m_diag = 0;
		rd_chk(4'h5, m_diag);
		pulse_lce;
		m_diag = 'h40;
		rd_chk(4'h5, m_diag);
		chk(ef, 0);
		@(posedge clk) hr <= 1;
		@(posedge clk) hr <= 0;
		m_diag = 0;
		rd_chk(4'h5, m_diag);
		@(posedge clk) {sel, lp} <= 3'b110;
		i_dfc_host.put(4'h8, 8'h00);
		wait_tests;
		chk(nl + nx, 0);
		i_dfc_host.put(4'h8, 8'h10);
		wait_tests;
		m_diag = 'h10;
		chk(nl > 18 && nl < 22, 1);
		chk(nx > 38 && nx < 42, 1);
		rd_chk(4'h5, m_diag);
		@(posedge clk) {sel, lp, xp} <= 4'b1010;
		i_dfc_host.put(4'h8, 8'h10);
		wait_tests;
		m_diag = 'h18;
		chk(nl, 0);
		rd_chk(4'h5, m_diag);
		@(posedge clk) {raw, rf} <= {12'($urandom), 12'($urandom)};
		repeat (3) @(posedge clk);
		chk(ao, 12'(raw - rf));
		@(posedge clk) rf <= 0;
		repeat (3) @(posedge clk);
		rf <= ao;
		repeat (3) @(posedge clk);
		chk(ao, 0);
		@(posedge clk) nrst <= 0;
		@(posedge clk) nrst <= 1;
		rd_chk(4'h8, 13'h4);
		rd_chk(4'h5, 0);
		chk(ef, 0);
		final_report;
	end
endmodule // dfc_regs_bench

/* dfc_test_timer.sv */
// Purpose: Down-counter timing one self-test window
// Assumes: Start is ignored while a window runs
// Notes:   Done is a one-cycle registered pulse at the end of the window

`timescale 1ns/1ps

module dfc_test_timer (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       nrst,
	// Control
	input  wire logic                       start,
	input  wire logic [dfc_pkg::CNT_W-1:0]  length,
	// Status
	output logic                            running,
	output logic                            done
);
	logic [dfc_pkg::CNT_W-1:0] cnt_r;

	// Count down the window; a zero length still lasts one cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r   <= '0;
			running <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !running) begin
				cnt_r   <= (length == '0) ? '0 : length - 1'b1;
				running <= 1'b1;
			end else if (running) begin
				if (cnt_r == '0) begin
					running <= 1'b0;
					done    <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
			end
		end
	end
endmodule // dfc_test_timer
